// >>> logic/ppad_pkg.sv
// Functional notes
// - with a PC range enabled, answer at exactly one of 3BC-3BE, 378-37F, 278-27F.
// - always answer in the reserved area from C000, whatever range is enabled.
// - base in the reserved area comes from the slot position, distinct per slot.
// - reserved-area access is decoded as slot base plus register offset.
// - configuration register sits at offset 00 from the slot base.
// - eight read/write parallel-port registers sit at offsets 10 through 17.
// - writing FE or 02 selects range 278; upper written bits are don't-care.
// - the eight data lines can drive out or be read as inputs.
// - config bits 1:0 select none (default), 378, 278 or 3BC.
// - config bits 7:2 ignore writes and always read back as ones.
// - one interrupt request line is raised for the parallel port.
package ppad_pkg;
	typedef enum logic [1:0] {
		PPAD_MODE_RSVD = 2'h0,
		PPAD_MODE_378  = 2'h1,
		PPAD_MODE_278  = 2'h2,
		PPAD_MODE_3BC  = 2'h3
	} ppad_mode_t;

	localparam logic [15:0] RSVD_AREA_BASE = 16'hc000;
	localparam logic [15:0] SLOT_STRIDE    = 16'h0020;
	localparam logic [15:0] PC_BASE_3BC    = 16'h03bc;
	localparam logic [15:0] PC_LAST_3BC    = 16'h03be;
	localparam logic [15:0] PC_BASE_378    = 16'h0378;
	localparam logic [15:0] PC_BASE_278    = 16'h0278;
	localparam logic [4:0]  OFS_CONFIG     = 5'h00;
	localparam logic [4:0]  OFS_WINDOW     = 5'h10;
	localparam logic [5:0]  CFG_ONES       = 6'h3f;
	localparam logic [7:0]  WIN_RESET      = 8'h00;
	localparam int          IDX_DATA       = 0;
	localparam int          IDX_STAT       = 1;
	localparam int          IDX_CTRL       = 2;
	localparam int          CTRL_IRQ_EN    = 4;
	localparam int          CTRL_DIR_IN    = 5;
	localparam int          STAT_ACK_N     = 6;
endpackage

// >>> logic/ppad_dec_if.sv
`timescale 1ns/100ps
`default_nettype none
interface ppad_dec_if;
	logic [15:0]         addr;
	logic [3:0]          slot;
	ppad_pkg::ppad_mode_t mode;
	logic                hit_cfg;
	logic                hit_win;
	logic [2:0]          win_idx;

	modport dec (input addr, input slot, input mode, output hit_cfg, output hit_win,
		output win_idx);
	modport top (output addr, output slot, output mode, input hit_cfg, input hit_win,
		input win_idx);
endinterface
`default_nettype wire

// >>> logic/ppad_decode.sv
`timescale 1ns/100ps
`default_nettype none
module ppad_decode (
	ppad_dec_if.dec d
);
	logic [15:0] slot_base;
	logic [15:0] rel;

	// slot base scaled by the stride, stride kept above the 0x17 top offset
	assign slot_base = ppad_pkg::RSVD_AREA_BASE
		+ 16'(d.slot) * ppad_pkg::SLOT_STRIDE;
	assign rel = d.addr - slot_base;

	always_comb begin
		logic rsvd_in;
		rsvd_in = 1'b0;
		d.hit_cfg = 1'b0;
		d.hit_win = 1'b0;
		d.win_idx = 3'h0;
		rsvd_in = (d.addr >= slot_base) && (rel < ppad_pkg::SLOT_STRIDE);
		if (rsvd_in && rel[4:0] == ppad_pkg::OFS_CONFIG) begin
			d.hit_cfg = 1'b1;
		end else if (rsvd_in && rel[4:3] == ppad_pkg::OFS_WINDOW[4:3]) begin
			d.hit_win = 1'b1;
			d.win_idx = rel[2:0];
		end else begin
			// only the selected range decodes; others stay silent
			case (d.mode)
				ppad_pkg::PPAD_MODE_378: begin
					if (d.addr[15:3] == ppad_pkg::PC_BASE_378[15:3]) begin
						d.hit_win = 1'b1;
						d.win_idx = d.addr[2:0];
					end
				end
				ppad_pkg::PPAD_MODE_278: begin
					if (d.addr[15:3] == ppad_pkg::PC_BASE_278[15:3]) begin
						d.hit_win = 1'b1;
						d.win_idx = d.addr[2:0];
					end
				end
				ppad_pkg::PPAD_MODE_3BC: begin
					if (d.addr >= ppad_pkg::PC_BASE_3BC && d.addr <= ppad_pkg::PC_LAST_3BC) begin
						d.hit_win = 1'b1;
						d.win_idx = 3'(d.addr - ppad_pkg::PC_BASE_3BC);
					end
				end
				default: begin
					d.hit_win = 1'b0;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> logic/ppad_top.sv
`timescale 1ns/100ps
`default_nettype none
module ppad_top (
	// clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        resetn_i,
	// host i/o bus
	input  wire logic [15:0] io_addr_i,
	input  wire logic        io_rd_i,
	input  wire logic        io_wr_i,
	input  wire logic [7:0]  io_wdata_i,
	output logic             io_claim_o,
	output logic [7:0]       io_rdata_o,
	// slot position strap
	input  wire logic [3:0]  slot_pos_i,
	// parallel connector
	input  wire logic [7:0]  pdata_i,
	output logic [7:0]       pdata_o,
	output logic             pdata_oe_n_o,
	input  wire logic        pack_n_i,
	// interrupt
	output logic             port_irq_request_o
);
	ppad_dec_if dif ();

	ppad_pkg::ppad_mode_t mode_q;
	logic [7:0]  win_q [8];
	logic [3:0]  slot_s1_q, slot_s2_q, slot_s3_q, slot_q;
	logic [7:0]  pd_s1_q, pd_s2_q, pd_s3_q, pd_q;
	logic [2:0]  ack_s_q;
	logic        ack_n_q;
	logic        hit;
	logic [7:0]  rdata_d;

	assign dif.addr = io_addr_i;
	assign dif.slot = slot_q;
	assign dif.mode = mode_q;

	ppad_decode u_dec (
		.d (dif)
	);

	assign hit = dif.hit_cfg | dif.hit_win;
	assign io_claim_o = (io_rd_i | io_wr_i) & hit;

	// slot strap and pins pass three flops; change taken when 2nd and 3rd agree
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			slot_s1_q <= 4'h0;
			slot_s2_q <= 4'h0;
			slot_s3_q <= 4'h0;
			slot_q    <= 4'h0;
		end else begin
			slot_s1_q <= slot_pos_i;
			slot_s2_q <= slot_s1_q;
			slot_s3_q <= slot_s2_q;
			if (slot_s2_q == slot_s3_q) begin
				slot_q <= slot_s3_q;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			pd_s1_q <= 8'h00;
			pd_s2_q <= 8'h00;
			pd_s3_q <= 8'h00;
			pd_q    <= 8'h00;
			ack_s_q <= 3'h7;
			ack_n_q <= 1'b1;
		end else begin
			pd_s1_q <= pdata_i;
			pd_s2_q <= pd_s1_q;
			pd_s3_q <= pd_s2_q;
			if (pd_s2_q == pd_s3_q) begin
				pd_q <= pd_s3_q;
			end
			ack_s_q <= {ack_s_q[1:0], pack_n_i};
			if (ack_s_q[1] == ack_s_q[2]) begin
				ack_n_q <= ack_s_q[2];
			end
		end
	end

	// only the range field is stored, so FE and 02 both land on 278
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			mode_q <= ppad_pkg::PPAD_MODE_RSVD;
		end else if (io_wr_i && dif.hit_cfg) begin
			mode_q <= ppad_pkg::ppad_mode_t'(io_wdata_i[1:0]);
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < 8; i++) begin
				win_q[i] <= ppad_pkg::WIN_RESET;
			end
		end else if (io_wr_i && dif.hit_win) begin
			win_q[dif.win_idx] <= io_wdata_i;
		end
	end

	// data lines: output latch driven unless the direction bit turns them round
	assign pdata_o      = win_q[ppad_pkg::IDX_DATA];
	assign pdata_oe_n_o = win_q[ppad_pkg::IDX_CTRL][ppad_pkg::CTRL_DIR_IN];

	always_comb begin
		rdata_d = 8'h00;
		if (dif.hit_cfg) begin
			rdata_d = {ppad_pkg::CFG_ONES, mode_q};
		end else if (dif.hit_win) begin
			rdata_d = win_q[dif.win_idx];
			if (dif.win_idx == 3'(ppad_pkg::IDX_DATA) && pdata_oe_n_o) begin
				rdata_d = pd_q;
			end else if (dif.win_idx == 3'(ppad_pkg::IDX_STAT)) begin
				rdata_d[ppad_pkg::STAT_ACK_N] = ack_n_q;
			end
		end
	end

	// read data registered: valid the cycle after the read strobe
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			io_rdata_o <= 8'h00;
		end else if (io_rd_i) begin
			io_rdata_o <= rdata_d;
		end
	end

	// a level request while acknowledge is low and interrupts are enabled
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			port_irq_request_o <= 1'b0;
		end else begin
			port_irq_request_o <= win_q[ppad_pkg::IDX_CTRL][ppad_pkg::CTRL_IRQ_EN]
				& ~ack_n_q;
		end
	end

	// slot base worked out again here, so the assertions do not lean on the decoder
	function automatic logic [15:0] slot_base_of(input logic [3:0] slot);
		slot_base_of = ppad_pkg::RSVD_AREA_BASE + 16'(slot) * ppad_pkg::SLOT_STRIDE;
	endfunction

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);

	// pc-compatible ranges: only the selected one answers
	AST_PC_378: assert property (mode_q == ppad_pkg::PPAD_MODE_378 && io_rd_i
		&& io_addr_i == 16'h037f |-> io_claim_o) else $error("378 range not claimed");
	AST_PC_278: assert property (mode_q == ppad_pkg::PPAD_MODE_278 && io_rd_i
		&& io_addr_i == 16'h027f |-> io_claim_o) else $error("278 range not claimed");
	AST_PC_3BC: assert property (mode_q == ppad_pkg::PPAD_MODE_3BC && io_rd_i
		&& io_addr_i == 16'h03be |-> io_claim_o) else $error("3bc range not claimed");
	AST_PC_EXCL: assert property (mode_q != ppad_pkg::PPAD_MODE_278 && io_rd_i
		&& io_addr_i == 16'h027f |-> !io_claim_o) else $error("278 claimed while off");
	AST_378_EXCL: assert property (mode_q != ppad_pkg::PPAD_MODE_378 && io_rd_i
		&& io_addr_i == 16'h037f |-> !io_claim_o) else $error("378 claimed while off");
	AST_3BC_EXCL: assert property (mode_q != ppad_pkg::PPAD_MODE_3BC && io_rd_i
		&& io_addr_i == 16'h03be |-> !io_claim_o) else $error("3bc claimed while off");
	AST_3BC_TOP: assert property (io_rd_i && io_addr_i == 16'h03bf |-> !io_claim_o)
		else $error("address past the 3bc range claimed");

	// reserved area: slot base plus offset, nothing else
	AST_RSVD_CFG: assert property (io_rd_i && io_addr_i == slot_base_of(slot_q)
		|-> io_claim_o) else $error("cfg not claimed");
	AST_WIN_CLAIM: assert property (io_rd_i
		&& io_addr_i == slot_base_of(slot_q) + 16'h0017 |-> io_claim_o)
		else $error("top window register not claimed");
	AST_OTHER_SLOT: assert property (io_rd_i
		&& io_addr_i == (slot_base_of(slot_q) ^ 16'h0020) |-> !io_claim_o)
		else $error("neighbouring slot claimed");
	AST_SLOT_TRACK: assert property ($stable(slot_pos_i) [*5]
		|-> slot_q == $past(slot_pos_i, 4)) else $error("slot strap not followed");
	AST_UNMAPPED: assert property (io_rd_i
		&& io_addr_i == slot_base_of(slot_q) + 16'h000f |-> !io_claim_o)
		else $error("unmapped offset claimed");
	AST_UNMAP_RD: assert property (io_rd_i && !io_claim_o |=> io_rdata_o == 8'h00)
		else $error("unclaimed read returned data");
	AST_UNMAP_WR: assert property (io_wr_i && !io_claim_o |=> $stable(mode_q))
		else $error("unclaimed write changed the range");
	AST_NO_STROBE: assert property (!io_rd_i && !io_wr_i |-> !io_claim_o)
		else $error("claim without a strobe");

	// configuration register
	AST_CFG_278: assert property (io_wr_i && dif.hit_cfg && io_wdata_i[1:0] == 2'h2
		|=> mode_q == ppad_pkg::PPAD_MODE_278) else $error("278 not selected");
	AST_CFG_MODE: assert property (io_wr_i && dif.hit_cfg
		|=> mode_q == $past(io_wdata_i[1:0])) else $error("range field not stored");
	AST_CFG_RD: assert property (io_rd_i && dif.hit_cfg
		|=> io_rdata_o[1:0] == $past(mode_q)) else $error("range field not read back");
	AST_CFG_ONES: assert property (io_rd_i && dif.hit_cfg
		|=> io_rdata_o[7:2] == 6'h3f) else $error("upper config bits not ones");
	AST_RESET_MODE: assert property ($rose(resetn_i) |-> mode_q == ppad_pkg::PPAD_MODE_RSVD)
		else $error("mode not reserved-only after reset");

	// window registers and data lines
	AST_WIN_RW: assert property (io_wr_i && dif.hit_win && dif.win_idx == 3'h3
		##1 !io_wr_i ##1 io_rd_i && dif.hit_win && dif.win_idx == 3'h3 && !io_wr_i
		|=> io_rdata_o == $past(io_wdata_i, 3)) else $error("window readback wrong");
	AST_DIR: assert property (io_wr_i && dif.hit_win && dif.win_idx == 3'h0
		|=> pdata_o == $past(io_wdata_i)) else $error("data lines do not follow the latch");
	AST_DIR_OE: assert property (io_wr_i && dif.hit_win && dif.win_idx == 3'h2
		|=> pdata_oe_n_o == $past(io_wdata_i[5])) else $error("direction bit not applied");
	AST_IN_READ: assert property (io_rd_i && dif.hit_win && dif.win_idx == 3'h0
		&& pdata_oe_n_o |=> io_rdata_o == $past(pd_q)) else $error("input lines not read back");

	// interrupt request
	AST_IRQ: assert property (win_q[2][4] && !ack_n_q |=> port_irq_request_o)
		else $error("irq not raised");
	AST_IRQ_OFF: assert property (!win_q[2][4] |=> !port_irq_request_o)
		else $error("irq raised while disabled");

	COV_CFG_WR: cover property (io_wr_i && dif.hit_cfg);
	COV_PC_3BC: cover property (mode_q == ppad_pkg::PPAD_MODE_3BC && io_claim_o);
	COV_DIR_IN: cover property (pdata_oe_n_o && io_rd_i && dif.hit_win);
	COV_IRQ: cover property (port_irq_request_o);
	COV_UNMAPPED: cover property (io_rd_i && !io_claim_o);
endmodule
`default_nettype wire

// >>> test/ppad_peer_model.sv
`timescale 1ns/100ps
`default_nettype none
module ppad_peer_model (
	// clock
	input  wire logic       sys_clk_i,
	// device side of the connector
	input  wire logic [7:0] pdata_o,
	input  wire logic       pdata_oe_n_o,
	// bench commands
	input  wire logic       peer_en_i,
	input  wire logic [7:0] peer_val_i,
	input  wire logic       ack_req_i,
	// resolved connector lines
	output wire logic [7:0] pdata_i,
	output wire logic       pack_n_i
);
	// undriven lines show the inverse of the latch so a stale value never passes for data
	assign pdata_i  = !pdata_oe_n_o ? pdata_o : (peer_en_i ? peer_val_i : ~pdata_o);
	assign pack_n_i = ~ack_req_i;
endmodule
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic            sys_clk_i = 1'b0;
	logic            resetn_i = 1'b0;
	logic [15:0]     io_addr_i = 16'h0000;
	logic            io_rd_i = 1'b0;
	logic            io_wr_i = 1'b0;
	logic [7:0]      io_wdata_i = 8'h00;
	logic [3:0]      slot_pos_i = 4'h0;
	logic [7:0]      peer_val = 8'h00;
	logic            peer_en = 1'b0;
	logic            ack_req = 1'b0;
	wire logic [7:0] pdata_i, pdata_o, io_rdata_o;
	wire logic       io_claim_o, pdata_oe_n_o, pack_n_i, port_irq_request_o;
	logic [7:0]      exp_q[$];
	logic [7:0]      win[8];
	logic [15:0]     offs[4] = '{16'h0001, 16'h000f, 16'h0018, 16'h001f};
	logic [15:0]     base;
	logic [7:0]      e;
	logic [7:0]      r;
	int              n_errors = 0;
	int              cmp_count = 0;
	int              m;
	int              k;

	always #2 sys_clk_i = ~sys_clk_i;

	ppad_top uut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .io_addr_i(io_addr_i),
		.io_rd_i(io_rd_i), .io_wr_i(io_wr_i), .io_wdata_i(io_wdata_i),
		.io_claim_o(io_claim_o), .io_rdata_o(io_rdata_o), .slot_pos_i(slot_pos_i),
		.pdata_i(pdata_i), .pdata_o(pdata_o), .pdata_oe_n_o(pdata_oe_n_o),
		.pack_n_i(pack_n_i), .port_irq_request_o(port_irq_request_o));
	ppad_peer_model peer (.sys_clk_i(sys_clk_i), .pdata_o(pdata_o),
		.pdata_oe_n_o(pdata_oe_n_o), .peer_en_i(peer_en), .peer_val_i(peer_val),
		.ack_req_i(ack_req), .pdata_i(pdata_i), .pack_n_i(pack_n_i));

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one bus cycle; the read result is noted for the monitor
	task automatic io(input logic [15:0] a, input logic rd, input logic wr,
		input logic [7:0] d, input logic clm, input logic [7:0] rexp);
		@(posedge sys_clk_i);
		#1;
		io_addr_i = a;
		io_rd_i = rd;
		io_wr_i = wr;
		io_wdata_i = d;
		if (rd) begin
			exp_q.push_back(rexp);
		end
		#1;
		chk("claim", {7'h00, clm}, {7'h00, io_claim_o});
		@(posedge sys_clk_i);
		#1;
		io_rd_i = 1'b0;
		io_wr_i = 1'b0;
	endtask

	always @(posedge sys_clk_i) begin
		if (io_rd_i === 1'b1) begin
			#2;
			r = exp_q.pop_front();
			chk("rdata", r, io_rdata_o);
		end
	end

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		void'($urandom(32'h6befb9e1));
		slot_pos_i = 4'($urandom_range(15));
		base = 16'hc000 + {7'h00, slot_pos_i, 5'h00};
		foreach (win[j]) win[j] = 8'h00;
		repeat (6) @(posedge sys_clk_i);
		#1;
		resetn_i = 1'b1;
		repeat (6) @(posedge sys_clk_i);
		io(base, 1, 0, 8'h00, 1, 8'hfc);
		io(base ^ 16'h0020, 1, 0, 8'h00, 0, 8'h00);
		$display("test reset and slot done");
		for (m = 0; m < 4; m++) begin
			io(base, 0, 1, (m == 2) ? 8'hfe : {6'($urandom), 2'(m)}, 1, 8'h00);
			io(base, 1, 0, 8'h00, 1, {6'h3f, 2'(m)});
			e = 8'($urandom);
			win[7] = e;
			io(base + 16'h0017, 0, 1, e, 1, 8'h00);
			io(16'h03be, 1, 0, 8'h00, m == 3, (m == 3) ? win[2] : 8'h00);
			io(16'h03bf, 1, 0, 8'h00, 0, 8'h00);
			io(16'h037f, 1, 0, 8'h00, m == 1, (m == 1) ? win[7] : 8'h00);
			io(16'h027f, 1, 0, 8'h00, m == 2, (m == 2) ? win[7] : 8'h00);
		end
		$display("test ranges done");
		foreach (offs[j]) io(base + offs[j], 1, 1, 8'hff, 0, 8'h00);
		for (k = 0; k < 8; k++) begin
			e = (k == 2) ? 8'($urandom) & 8'hcf : 8'($urandom);
			win[k] = e;
			io(base + 16'h0010 + 16'(k), 0, 1, e, 1, 8'h00);
			io(base + 16'h0010 + 16'(k), 1, 0, 8'h00, 1, (k == 1) ? e | 8'h40 : e);
		end
		chk("pdata", win[0], pdata_o);
		chk("oe_n", 8'h00, {7'h00, pdata_oe_n_o});
		$display("test window done");
		peer_en = 1'b1;
		peer_val = 8'($urandom);
		io(base + 16'h0012, 0, 1, 8'h30, 1, 8'h00);
		repeat (4) @(posedge sys_clk_i);
		io(base + 16'h0010, 1, 0, 8'h00, 1, peer_val);
		chk("oe_n", 8'h01, {7'h00, pdata_oe_n_o});
		ack_req = 1'b1;
		repeat (5) @(posedge sys_clk_i);
		#1;
		chk("irq", 8'h01, {7'h00, port_irq_request_o});
		ack_req = 1'b0;
		repeat (5) @(posedge sys_clk_i);
		#1;
		chk("irq", 8'h00, {7'h00, port_irq_request_o});
		$display("test direction and irq done");
		resetn_i = 1'b0;
		repeat (2) @(posedge sys_clk_i);
		#1;
		resetn_i = 1'b1;
		chk("oe_n", 8'h00, {7'h00, pdata_oe_n_o});
		chk("pdata", 8'h00, pdata_o);
		repeat (6) @(posedge sys_clk_i);
		io(base, 1, 0, 8'h00, 1, 8'hfc);
		$display("test mid-run reset done");
		conclude();
	end

	// the tests take well under 2000 cycles
	initial begin
		#40000;
		n_errors++;
		conclude();
	end
endmodule
`default_nettype wire
